//--- common/otpx_pkg.sv
`default_nettype none
package otpx_pkg;
  // =====================================================
  // framing
  localparam int IMG_W = 62;
  localparam int CMD_W = 5;
  localparam int NDATA_W = 16;
  localparam logic [1:0] XBIT_LAST_PHASE = 2'h3;
  localparam logic [4:0] CMD_UNLOCK = 5'h10;
  localparam logic [4:0] CMD_VOL_WRITE = 5'h1F;
  localparam logic [4:0] CMD_FUSE_PROGRAMMING_PIN = 5'h19;
  localparam logic [4:0] CMD_READBACK = 5'h0F;
  localparam logic [4:0] CMD_ANA_READ = 5'h09;
  localparam logic [15:0] UNLOCK_PATTERN = 16'h8CAE;
  // =====================================================
  // image fields
  localparam int ZERO_LSB = 0;
  localparam int ZERO_W = 9;
  localparam int POLE_LSB = 9;
  localparam int POLE_W = 3;
  localparam int ABI_LSB = 12;
  localparam int ABI_W = 2;
  localparam int GAIN_LSB = 14;
  localparam int GAIN_W = 2;
  localparam int RBIT_POS = 16;
  localparam int RADD_LSB = 17;
  localparam int RADD_W = 4;
  localparam int LOCK_POS = 21;
  localparam int TAG_LSB = 42;
  localparam int TAG_W = 18;
  localparam logic [61:0] CUST_MASK = 62'h00000000001FFFFF;
  localparam logic [61:0] IMG_RESET = 62'h0;
  localparam logic [9:0] ANGLE_STEPS = 10'h168;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMEOUT_NS = 20000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- logic/otpx_sync3.sv
`default_nettype none
module otpx_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end
  logic [W-1:0] s1_q, s2_q, s3_q, q_q;
  // a bit moves on only once stages two and three agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & q_q;
    end
  end
  assign q_o = q_q;
endmodule
`default_nettype wire

//--- logic/otpx_access.sv
// What this block does
// - extended mode opens only after the unlock command 16 in normal mode
// - in extended mode each data bit lasts four serial clocks
// - command 11111 loads the image volatile, no fuses blown
// - command 11001 burns only customer bits 0 to 20
// - factory region is never burned whatever data is shifted in
// - command 01111 shifts out the current image
// - command 01001 leaves the data line undriven
// - command 01001 presents image bits in turn on the programming pin
// - bits 8:0 hold the zero offset subtracted from the angle
// - bits 11:9 select the pole-pair count
// - bits 13:12 select the quadrature output mode
// - bits 15:14 set the amplifier gain
// - bit 16 is the repair value, applied in the customer region only
// - bits 20:17 address the customer bit 0 to 15 to repair
// - bit 21 locks factory fuses; volatile writes still reach them
// - bits 59:42 hold a readable chip trace tag
// - low power does not reset the digital registers
// - converter-locked status is cleared during sleep
// - first command bit tells read from write
// - unlock needs data pattern 1000110010101110
// - interface resets on chip select low (3-wire) or timeout (2-wire)
`default_nettype none
module otpx_access #(
  parameter int TIMEOUT_CYCLES = otpx_pkg::TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_line_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  input wire logic chip_select_i,
  input wire logic three_wire_mode_i,
  output logic programming_pin_o,
  output logic programming_pin_oe_o,
  input wire logic [61:0] fuse_state_i,
  output logic fuse_burn_o,
  output logic [61:0] fuse_burn_mask_o,
  input wire logic low_power_request_i,
  input wire logic adc_locked_i,
  input wire logic [8:0] raw_angle_i,
  output logic [8:0] angle_o,
  output logic converter_locked_o,
  output logic [8:0] zero_offset_o,
  output logic [2:0] pole_pair_sel_o,
  output logic [1:0] abi_mode_o,
  output logic [1:0] amp_gain_o,
  output logic [17:0] chip_trace_tag_o,
  output logic ext_unlocked_o
);
  localparam int TCW = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 4) begin : g_chk
    $error("TIMEOUT_CYCLES must be at least 4");
  end

  typedef enum logic [1:0] {L_CMD, L_NDATA, L_XDATA, L_DONE} otpx_lstate_t;

  function automatic logic [61:0] otpx_repair(input logic [61:0] img);
    logic [61:0] r;
    r = img;
    // an all-zero repair field means no repair; the address only spans bits 0..15
    if (img[otpx_pkg::RBIT_POS] || img[otpx_pkg::RADD_LSB +: otpx_pkg::RADD_W] != 4'h0) begin
      r[img[otpx_pkg::RADD_LSB +: otpx_pkg::RADD_W]] = img[otpx_pkg::RBIT_POS];
    end
    return r;
  endfunction

  // =====================================================
  // core-domain declarations
  logic link_rst_q;
  logic [61:0] image_q, snap_q;
  logic ack_q, load_q;
  logic [5:0] sync_s;
  logic cs_s, tw_s, act_s, wr_s, rd_s, unl_s;
  logic act_p_q, wr_p_q, rd_p_q;
  logic [TCW-1:0] tmo_q;

  // =====================================================
  // link domain: frame engine on the host's serial clock
  otpx_lstate_t lst_q, lst_d;
  logic frame_rst;
  logic [1:0] sub_q;
  logic [6:0] bit_q, bit_d;
  logic [4:0] cmd_q, cmd_next;
  logic [61:0] sh_q, sh_next;
  logic sdl_oe_q, pin_oe_q, sdl_oe_d, pin_oe_d;
  logic unlocked_l_q, rd_req_q, wr_req_q, act_l_q;
  logic [61:0] wr_data_q;
  logic [4:0] wr_cmd_q;
  logic ack_l, ext_mode, tick, cmd_last, ndata_last, xdata_last;
  logic rd_spec, unl_hit, img_write, ack_ok, load_rd, load_ana;

  // chip select low or a timeout ends the frame asynchronously; sclk is idle then
  assign frame_rst = rst_i | link_rst_q;
  assign ext_mode = unlocked_l_q;
  assign tick = !ext_mode || sub_q == otpx_pkg::XBIT_LAST_PHASE;
  assign cmd_next = {cmd_q[3:0], serial_data_line_i};
  assign sh_next = {sh_q[60:0], serial_data_line_i};
  assign cmd_last = lst_q == L_CMD && tick && bit_q == 7'(otpx_pkg::CMD_W - 1);
  assign ndata_last = lst_q == L_NDATA && tick && bit_q == 7'(otpx_pkg::NDATA_W - 1);
  assign xdata_last = lst_q == L_XDATA && tick && bit_q == 7'(otpx_pkg::IMG_W - 1);
  // a leading zero means read: ask the core for a snapshot while the command finishes
  assign rd_spec = lst_q == L_CMD && tick && bit_q == 7'h00 && ext_mode && !serial_data_line_i;
  assign unl_hit = ndata_last && cmd_q == otpx_pkg::CMD_UNLOCK
                   && sh_next[15:0] == otpx_pkg::UNLOCK_PATTERN;
  assign img_write = xdata_last && (cmd_q == otpx_pkg::CMD_VOL_WRITE || cmd_q == otpx_pkg::CMD_FUSE_PROGRAMMING_PIN);
  assign ack_ok = ack_l == rd_req_q;
  assign load_rd = cmd_last && ext_mode && ack_ok && cmd_next == otpx_pkg::CMD_READBACK;
  assign load_ana = cmd_last && ext_mode && ack_ok && cmd_next == otpx_pkg::CMD_ANA_READ;
  assign bit_d = (cmd_last || ndata_last || xdata_last) ? 7'h00 : bit_q + 7'h01;
  assign sdl_oe_d = load_rd ? 1'b1 : (xdata_last ? 1'b0 : sdl_oe_q);
  // analog readback never turns the data driver on
  assign pin_oe_d = load_ana ? 1'b1 : (xdata_last ? 1'b0 : pin_oe_q);

  always_comb begin
    lst_d = lst_q;
    case (lst_q)
      L_CMD: if (cmd_last) lst_d = ext_mode ? L_XDATA : L_NDATA;
      L_NDATA: if (ndata_last) lst_d = L_DONE;
      L_XDATA: if (xdata_last) lst_d = L_DONE;
      L_DONE: lst_d = L_DONE;
      default: lst_d = L_CMD;
    endcase
  end

  always_ff @(posedge serial_clock_line_i or posedge frame_rst) begin
    if (frame_rst) begin
      lst_q <= L_CMD;
      sub_q <= 2'h0;
      bit_q <= 7'h00;
      cmd_q <= 5'h00;
      sh_q <= otpx_pkg::IMG_RESET;
      sdl_oe_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      sub_q <= ext_mode ? sub_q + 2'h1 : 2'h0;
      if (tick) begin
        bit_q <= bit_d;
      end
      if (tick && lst_q == L_CMD) begin
        cmd_q <= cmd_next;
      end
      if (tick) begin
        sh_q <= (load_rd || load_ana) ? snap_q : sh_next;
      end
      sdl_oe_q <= sdl_oe_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // toggles live outside the frame reset so a frame abort never fakes an event
  always_ff @(posedge serial_clock_line_i or posedge rst_i) begin
    if (rst_i) begin
      unlocked_l_q <= 1'b0;
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      act_l_q <= 1'b0;
      wr_data_q <= otpx_pkg::IMG_RESET;
      wr_cmd_q <= 5'h00;
    end else begin
      act_l_q <= !act_l_q;
      if (unl_hit) begin
        unlocked_l_q <= 1'b1;
      end
      if (rd_spec) begin
        rd_req_q <= !rd_req_q;
      end
      if (img_write) begin
        wr_req_q <= !wr_req_q;
        wr_data_q <= sh_next;
        wr_cmd_q <= cmd_q;
      end
    end
  end

  otpx_sync3 #(.W(1)) u_ack_sync (
    .clk_i(serial_clock_line_i),
    .rst_i(rst_i),
    .d_i(ack_q),
    .q_o(ack_l)
  );

  assign serial_data_line_o = sh_q[61];
  assign serial_data_line_oe_o = sdl_oe_q;
  assign programming_pin_o = sh_q[61];
  assign programming_pin_oe_o = pin_oe_q;

  // =====================================================
  // core domain
  otpx_sync3 #(.W(6)) u_core_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({chip_select_i, three_wire_mode_i, act_l_q, wr_req_q, rd_req_q, unlocked_l_q}),
    .q_o(sync_s)
  );

  logic wr_ev, rd_ev, act_ev, tmo_hit, vol_ev, programming_pin_ev;
  logic [61:0] burn_mask, eff_img;
  logic [9:0] ang_rel;
  assign {cs_s, tw_s, act_s, wr_s, rd_s, unl_s} = sync_s;
  assign wr_ev = wr_s ^ wr_p_q;
  assign rd_ev = rd_s ^ rd_p_q;
  assign act_ev = act_s ^ act_p_q;
  assign vol_ev = wr_ev && wr_cmd_q == otpx_pkg::CMD_VOL_WRITE;
  assign programming_pin_ev = wr_ev && wr_cmd_q == otpx_pkg::CMD_FUSE_PROGRAMMING_PIN;
  // factory bits and the lock bit never reach the fuses
  assign burn_mask = wr_data_q & otpx_pkg::CUST_MASK;
  assign tmo_hit = !act_ev && tmo_q == TCW'(TIMEOUT_CYCLES - 1);
  assign eff_img = otpx_repair(image_q);
  assign ang_rel = (raw_angle_i >= zero_offset_o)
                   ? {1'b0, raw_angle_i} - {1'b0, zero_offset_o}
                   : {1'b0, raw_angle_i} + otpx_pkg::ANGLE_STEPS - {1'b0, zero_offset_o};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_p_q <= 1'b0;
      wr_p_q <= 1'b0;
      rd_p_q <= 1'b0;
      ack_q <= 1'b0;
      load_q <= 1'b1;
      tmo_q <= '0;
      link_rst_q <= 1'b1;
    end else begin
      act_p_q <= act_s;
      wr_p_q <= wr_s;
      rd_p_q <= rd_s;
      ack_q <= rd_s;
      load_q <= 1'b0;
      tmo_q <= act_ev ? '0 : (tmo_hit || tmo_q == TCW'(TIMEOUT_CYCLES)) ? TCW'(TIMEOUT_CYCLES) : tmo_q + 1'b1;
      link_rst_q <= tw_s ? !cs_s : tmo_hit;
    end
  end

  // fuses are read in once after reset; low power leaves the image alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      image_q <= otpx_pkg::IMG_RESET;
      snap_q <= otpx_pkg::IMG_RESET;
      fuse_burn_o <= 1'b0;
      fuse_burn_mask_o <= otpx_pkg::IMG_RESET;
    end else begin
      if (load_q) begin
        image_q <= fuse_state_i;
      end else if (vol_ev) begin
        image_q <= wr_data_q;
      end else if (programming_pin_ev) begin
        image_q <= image_q | burn_mask;
      end
      if (rd_ev) begin
        snap_q <= image_q;
      end
      fuse_burn_o <= programming_pin_ev && !load_q;
      if (programming_pin_ev) begin
        fuse_burn_mask_o <= burn_mask;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_offset_o <= 9'h000;
      pole_pair_sel_o <= 3'h0;
      abi_mode_o <= 2'h0;
      amp_gain_o <= 2'h0;
      chip_trace_tag_o <= 18'h00000;
      angle_o <= 9'h000;
      converter_locked_o <= 1'b0;
      ext_unlocked_o <= 1'b0;
    end else begin
      zero_offset_o <= eff_img[otpx_pkg::ZERO_LSB +: otpx_pkg::ZERO_W];
      pole_pair_sel_o <= eff_img[otpx_pkg::POLE_LSB +: otpx_pkg::POLE_W];
      abi_mode_o <= eff_img[otpx_pkg::ABI_LSB +: otpx_pkg::ABI_W];
      amp_gain_o <= eff_img[otpx_pkg::GAIN_LSB +: otpx_pkg::GAIN_W];
      chip_trace_tag_o <= image_q[otpx_pkg::TAG_LSB +: otpx_pkg::TAG_W];
      angle_o <= ang_rel[8:0];
      converter_locked_o <= adc_locked_i && !low_power_request_i;
      ext_unlocked_o <= unl_s;
    end
  end

  // =====================================================
  // checks
  a_burn_customer: assert property (@(posedge clk_i) disable iff (rst_i)
    fuse_burn_o |-> (fuse_burn_mask_o & ~otpx_pkg::CUST_MASK) == 62'h0)
    else $error("fuse burn outside customer bits");
  a_factory_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (programming_pin_ev && !load_q) |=> image_q[61:21] == $past(image_q[61:21]))
    else $error("fuse program changed factory bits");
  a_volatile_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (vol_ev && !load_q) |=> image_q == $past(wr_data_q) && !fuse_burn_o)
    else $error("volatile write not loaded");
  a_sleep_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    low_power_request_i |=> !converter_locked_o)
    else $error("lock status kept in sleep");
  a_sleep_keeps_img: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_power_request_i && !wr_ev && !load_q) |=> $stable(image_q))
    else $error("sleep disturbed image");
  a_angle_zero_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    (raw_angle_i == zero_offset_o) |=> angle_o == 9'h000)
    else $error("zero offset not applied");
  a_iface_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    (!tw_s && tmo_hit) || (tw_s && !cs_s) |=> link_rst_q)
    else $error("interface reset missed");
  a_bit_four_clks: assert property (@(posedge serial_clock_line_i) disable iff (frame_rst)
    (ext_mode && sub_q != 2'h0) |-> $stable(sh_q))
    else $error("extended bit shorter than four clocks");
  a_ana_line_quiet: assert property (@(posedge serial_clock_line_i) disable iff (frame_rst)
    pin_oe_q |-> !sdl_oe_q)
    else $error("data line driven in analog readback");
  a_ana_pin_drive: assert property (@(posedge serial_clock_line_i) disable iff (frame_rst)
    load_ana |=> pin_oe_q && programming_pin_o == $past(snap_q[61]))
    else $error("programming pin not driven");
  a_ext_needs_unlock: assert property (@(posedge serial_clock_line_i) disable iff (frame_rst)
    lst_q == L_XDATA |-> unlocked_l_q)
    else $error("extended frame while locked");

  c_unlock: cover property (@(posedge serial_clock_line_i) disable iff (frame_rst) unl_hit);
  c_vol_write: cover property (@(posedge clk_i) disable iff (rst_i) vol_ev);
  c_fuse_programming_pin: cover property (@(posedge clk_i) disable iff (rst_i) fuse_burn_o);
  c_analog: cover property (@(posedge serial_clock_line_i) disable iff (frame_rst) load_ana);
endmodule
`default_nettype wire

//--- tb/otpx_host.sv
`default_nettype none
module otpx_host (
  input wire logic sdl_i,
  input wire logic pin_i,
  output logic sclk_o,
  output logic sdl_o,
  output logic cs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    sdl_o = 1'b0;
    cs_o = 1'b0;
  end
  // =====================================================
  // one frame; the serial clock stands still outside it
  task automatic xfer(input logic [4:0] cmd, input logic [61:0] dat, input int nd, input bit ext,
                      input bit ana, output logic [61:0] rd);
    int n;
    logic b;
    n = ext ? 4 : 1;
    rd = '0;
    cs_o = 1'b1;
    // odd delay keeps the serial clock out of step with the core clock
    #101;
    for (int i = 0; i < 5 + nd; i++) begin
      b = (i < 5) ? cmd[4-i] : dat[nd+4-i];
      for (int k = 0; k < n; k++) begin
        // released line during reads: toggling pattern, never the last value
        sdl_o = (i >= 5 && !cmd[4]) ? ~sdl_o : b;
        #32 sclk_o = 1'b1;
        #32 sclk_o = 1'b0;
        if (i >= 5 && k == 1) begin
          rd[nd+4-i] = ana ? pin_i : sdl_i;
        end
      end
    end
    cs_o = 1'b0;
    // gap longer than both the select-low reset and the idle timeout
    #1200;
  endtask
endmodule
`default_nettype wire

//--- tb/otpx_access_tb.sv
`default_nettype none
module otpx_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [61:0] FUSE = 62'h2ABCDE01230000F3;
  typedef struct packed {
    logic [21:0] cust;
    logic [8:0] zo;
    logic [2:0] pp;
    logic [1:0] abi;
    logic [1:0] gn;
  } otpx_row_t;
  otpx_row_t rows [6] = '{
    '{22'h000000, 9'h000, 3'h0, 2'h0, 2'h0}, '{22'h00FFFF, 9'h1FF, 3'h7, 2'h3, 2'h3},
    '{22'h20A5A5, 9'h1A5, 3'h2, 2'h2, 2'h2}, '{22'h070000, 9'h008, 3'h0, 2'h0, 2'h0},
    '{22'h150000, 9'h000, 3'h2, 2'h0, 2'h0}, '{22'h020002, 9'h000, 3'h0, 2'h0, 2'h0}};
  logic clk_i, rst_i, sclk, sdl_h, cs, three_w, lp, adc_lock, dut_d, dut_oe, pin, pin_oe, burn, locked, unl;
  logic [8:0] raw, angle, zo;
  logic [61:0] bmask, img, rd;
  logic [2:0] pp;
  logic [1:0] abi, gn;
  logic [17:0] tag;
  logic sdl;
  int miscompares = 0;
  int n_tests = 0;
  int burns = 0;
  int bad_oe = 0;
  bit ana_on = 0;
  bit pin_seen = 0;
  assign sdl = dut_oe ? dut_d : sdl_h;
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  otpx_access #(.TIMEOUT_CYCLES(64)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_line_i(sclk),
    .serial_data_line_i(sdl), .serial_data_line_o(dut_d), .serial_data_line_oe_o(dut_oe), .chip_select_i(cs),
    .three_wire_mode_i(three_w), .programming_pin_o(pin), .programming_pin_oe_o(pin_oe), .fuse_state_i(FUSE),
    .fuse_burn_o(burn), .fuse_burn_mask_o(bmask), .low_power_request_i(lp), .adc_locked_i(adc_lock),
    .raw_angle_i(raw), .angle_o(angle), .converter_locked_o(locked), .zero_offset_o(zo), .pole_pair_sel_o(pp),
    .abi_mode_o(abi), .amp_gain_o(gn), .chip_trace_tag_o(tag), .ext_unlocked_o(unl));
  otpx_host host_u (.sdl_i(sdl), .pin_i(pin), .sclk_o(sclk), .sdl_o(sdl_h), .cs_o(cs));
  always @(posedge clk_i) begin
    if (burn === 1'b1) burns++;
    if (ana_on && dut_oe !== 1'b0) bad_oe++;
    if (ana_on && pin_oe === 1'b1) pin_seen = 1;
  end
  // =====================================================
  // checking
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    chk(unl, 1'b0);
    rst_i = 1'b0;
    repeat (12) @(negedge clk_i);
  endtask
  initial begin
    // the full sequence needs about 356 us
    #380_000;
    miscompares++;
    close_out();
  end
  // =====================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    three_w = 1'b1;
    lp = 1'b0;
    adc_lock = 1'b1;
    raw = 9'd100;
    do_reset();
    chk(zo, FUSE[8:0]);
    chk(tag, FUSE[59:42]);
    host_u.xfer(otpx_pkg::CMD_VOL_WRITE, '0, 62, 1, 0, rd);
    chk(zo, FUSE[8:0]);
    host_u.xfer(otpx_pkg::CMD_UNLOCK, 62'h8CAF, 16, 0, 0, rd);
    chk(unl, 1'b0);
    host_u.xfer(otpx_pkg::CMD_UNLOCK, 62'h8CAE, 16, 0, 0, rd);
    chk(unl, 1'b1);
    foreach (rows[r]) begin
      img = {FUSE[61:22], rows[r].cust};
      host_u.xfer(otpx_pkg::CMD_VOL_WRITE, img, 62, 1, 0, rd);
      chk(zo, rows[r].zo);
      chk(pp, rows[r].pp);
      chk(abi, rows[r].abi);
      chk(gn, rows[r].gn);
      host_u.xfer(otpx_pkg::CMD_READBACK, '0, 62, 1, 0, rd);
      chk(rd, img);
    end
    img = {FUSE[61:22], 22'h00001E};
    host_u.xfer(otpx_pkg::CMD_VOL_WRITE, img, 62, 1, 0, rd);
    @(negedge clk_i);
    raw = 9'd10;
    repeat (3) @(negedge clk_i);
    chk(angle, 9'd340);
    chk(locked, 1'b1);
    lp = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(locked, 1'b0);
    chk(zo, 9'd30);
    raw = 9'd30;
    repeat (2) @(negedge clk_i);
    chk(angle, 9'h000);
    lp = 1'b0;
    // test bits go back unchanged; lock and tag bits are pushed to ones
    host_u.xfer(otpx_pkg::CMD_FUSE_PROGRAMMING_PIN, {FUSE[61:60], 18'h3FFFF, FUSE[41:22], 22'h3FFFFF}, 62, 1, 0,
                rd);
    chk(bmask, otpx_pkg::CUST_MASK);
    chk(burns, 1);
    img = img | otpx_pkg::CUST_MASK;
    host_u.xfer(otpx_pkg::CMD_READBACK, '0, 62, 1, 0, rd);
    chk(rd, img);
    ana_on = 1;
    host_u.xfer(otpx_pkg::CMD_ANA_READ, '0, 62, 1, 1, rd);
    ana_on = 0;
    chk(rd, img);
    chk(bad_oe, 0);
    chk(pin_seen, 1'b1);
    // idle timeout must separate frames once chip select is ignored
    @(negedge clk_i);
    three_w = 1'b0;
    repeat (2) begin
      host_u.xfer(otpx_pkg::CMD_READBACK, '0, 62, 1, 0, rd);
      chk(rd, img);
    end
    @(negedge clk_i);
    three_w = 1'b1;
    do_reset();
    chk(unl, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
